/* File: src/usic_ctrl.sv */
/*
 * Interrupt controller of the 8-bit core: request flags, enables, fixed-priority
 * vectoring on the second-phase pulse, return handling and an APB register slave.
 * Assumes the sequencer delivers a one-cycle second-phase pulse, stack-full level,
 * return pulses and current pc, and pushes ack.push_pc and jumps on ack.valid.
 */
// Chosen here: the APB register port.
`timescale 1ns/1ps
module usic_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [usic_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire usic_pkg::usic_core_t core,
	input wire usic_pkg::usic_src_evt_t src_evt,
	input wire usic_pkg::usic_usb_evt_t usb_evt,
	output usic_pkg::usic_ack_t ack,
	output logic global_irq_enable,
	output logic in_service,
	output logic irq
);
	usic_pkg::usic_state_t q;
	usic_pkg::usic_state_t d;
	logic [5:0] idx;
	logic aligned;
	logic hit;
	logic [31:0] rd;
	logic [usic_pkg::NSRC-1:0] flags;
	logic [usic_pkg::NSRC-1:0] enables;
	logic [usic_pkg::NSRC-1:0] req;
	logic [2:0] win;
	logic any_req;
	logic take;
	logic blocked;
	logic usb_event;

	assign idx = paddr[7:2];
	assign aligned = (paddr[1:0] == usic_pkg::BYTE_OFS_ZERO);

	// read mux and decode; reserved bits of intc0, sec_ctl and usb_ctl are never stored so read zero, serial control stores all eight
	always_comb begin
		hit = aligned;
		rd = '0;
		case (idx)
			usic_pkg::IDX_INTC0: rd = 32'(q.intc0);
			usic_pkg::IDX_SEC_CTL: rd = 32'(q.sec_ctl);
			usic_pkg::IDX_EP_REQ: rd = 32'(q.ep_req);
			usic_pkg::IDX_USB_CTL: rd = 32'(q.usb_ctl);
			usic_pkg::IDX_SER1_CTL: rd = 32'(q.ser1_ctl);
			usic_pkg::IDX_SER2_CTL: rd = 32'(q.ser2_ctl);
			usic_pkg::IDX_EVT_STATUS: rd = 32'(q.evt_status);
			usic_pkg::IDX_EVT_MASK: rd = 32'(q.evt_mask);
			default: hit = 1'b0;
		endcase
	end

	// per-source flag and enable, source 0 first in priority
	always_comb begin
		flags = {q.sec_ctl[usic_pkg::B_SER2_FLAG], q.sec_ctl[usic_pkg::B_SER1_FLAG], q.sec_ctl[usic_pkg::B_USB_FLAG],
			q.intc0[usic_pkg::B_T1F], q.intc0[usic_pkg::B_T0F], q.intc0[usic_pkg::B_EIF]};
		enables = {q.sec_ctl[usic_pkg::B_ES2I] & q.ser2_ctl[usic_pkg::B_SER_EN],
			q.sec_ctl[usic_pkg::B_ES1I] & q.ser1_ctl[usic_pkg::B_SER_EN],
			q.sec_ctl[usic_pkg::B_EUI],
			q.intc0[usic_pkg::B_ET1I], q.intc0[usic_pkg::B_ET0I], q.intc0[usic_pkg::B_EEI]};
		req = flags & enables;
	end

	// fixed priority pick: lowest index wins, scanned from the top index down
	always_comb begin
		win = '0;
		for (int i = usic_pkg::NSRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				win = 3'(i);
			end
		end
	end

	// decisions only on the second-phase pulse, so requests gathered since the last one wait
	assign any_req = |req;
	assign take = core.phase2_pulse & q.intc0[usic_pkg::B_GIE] & any_req & ~core.stack_full;
	assign blocked = core.phase2_pulse & q.intc0[usic_pkg::B_GIE] & any_req & core.stack_full;
	assign usb_event = (|usb_evt.ep_access) | usb_evt.suspend | usb_evt.resume | usb_evt.bus_reset;

	// next state: bus access, then returns, then acknowledge, then hardware sets last so sets win
	always_comb begin
		d = q;
		d.ack.valid = 1'b0;
		// read data captured in setup so it comes from a flop in the access phase
		if (psel & ~penable) begin
			d.prdata = rd;
			d.pslverr = ~hit;
		end
		if (psel & penable & pwrite & pstrb[0] & hit) begin
			case (idx)
				usic_pkg::IDX_INTC0: d.intc0 = pwdata[7:0] & usic_pkg::INTC0_WMASK;
				usic_pkg::IDX_SEC_CTL: d.sec_ctl = pwdata[7:0] & usic_pkg::SEC_CTL_WMASK;
				usic_pkg::IDX_EP_REQ: d.ep_req = pwdata[usic_pkg::NEP-1:0];
				usic_pkg::IDX_USB_CTL: d.usb_ctl = pwdata[7:0] & usic_pkg::USB_CTL_WMASK;
				usic_pkg::IDX_SER1_CTL: d.ser1_ctl = pwdata[7:0];
				usic_pkg::IDX_SER2_CTL: d.ser2_ctl = pwdata[7:0];
				usic_pkg::IDX_EVT_STATUS: d.evt_status = q.evt_status & ~pwdata[usic_pkg::NEVT-1:0];
				usic_pkg::IDX_EVT_MASK: d.evt_mask = pwdata[usic_pkg::NEVT-1:0];
				default: d.in_service = d.in_service;
			endcase
		end
		// returns end service; only the interrupt return re-arms the global enable
		if (core.irq_return) begin
			d.intc0[usic_pkg::B_GIE] = 1'b1;
			d.in_service = 1'b0;
		end
		if (core.plain_return) begin
			d.in_service = 1'b0;
		end
		// acknowledge: clear the winner's flag and global enable, hand the pc to push
		if (take) begin
			case (win)
				3'h0: d.intc0[usic_pkg::B_EIF] = 1'b0;
				3'h1: d.intc0[usic_pkg::B_T0F] = 1'b0;
				3'h2: d.intc0[usic_pkg::B_T1F] = 1'b0;
				3'h3: d.sec_ctl[usic_pkg::B_USB_FLAG] = 1'b0;
				3'h4: d.sec_ctl[usic_pkg::B_SER1_FLAG] = 1'b0;
				3'h5: d.sec_ctl[usic_pkg::B_SER2_FLAG] = 1'b0;
				default: d.in_service = 1'b1;
			endcase
			d.intc0[usic_pkg::B_GIE] = 1'b0;
			d.in_service = 1'b1;
			d.ack.valid = 1'b1;
			d.ack.vector = usic_pkg::VECTOR_TABLE[win];
			d.ack.push_pc = core.pc;
		end
		// hardware sets come last: an event in the clearing cycle is kept
		d.intc0[usic_pkg::B_EIF] = d.intc0[usic_pkg::B_EIF] | src_evt.ext_fall;
		d.intc0[usic_pkg::B_T0F] = d.intc0[usic_pkg::B_T0F] | src_evt.timer0_ovf;
		d.intc0[usic_pkg::B_T1F] = d.intc0[usic_pkg::B_T1F] | src_evt.timer1_ovf;
		d.sec_ctl[usic_pkg::B_SER1_FLAG] = d.sec_ctl[usic_pkg::B_SER1_FLAG] | src_evt.serial1_done;
		d.sec_ctl[usic_pkg::B_SER2_FLAG] = d.sec_ctl[usic_pkg::B_SER2_FLAG] | src_evt.serial2_done;
		d.ep_req = d.ep_req | usb_evt.ep_access;
		d.usb_ctl[usic_pkg::B_SUSPEND] = d.usb_ctl[usic_pkg::B_SUSPEND] | usb_evt.suspend;
		d.usb_ctl[usic_pkg::B_RESUME] = d.usb_ctl[usic_pkg::B_RESUME] | usb_evt.resume;
		d.sec_ctl[usic_pkg::B_USB_FLAG] = d.sec_ctl[usic_pkg::B_USB_FLAG] | usb_event;
		d.evt_status[usic_pkg::E_ACK] = d.evt_status[usic_pkg::E_ACK] | take;
		d.evt_status[usic_pkg::E_STACK_BLOCK] = d.evt_status[usic_pkg::E_STACK_BLOCK] | blocked;
		d.evt_status[usic_pkg::E_BUS_RESET] = d.evt_status[usic_pkg::E_BUS_RESET] | usb_evt.bus_reset;
	end

	// whole block state in one register; reset leaves every interrupt disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= usic_pkg::STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// zero wait states: decode is cheap, and data was latched in setup
	assign pready = 1'b1;
	assign prdata = q.prdata;
	assign pslverr = q.pslverr;
	assign ack = q.ack;
	assign global_irq_enable = q.intc0[usic_pkg::B_GIE];
	assign in_service = q.in_service;
	assign irq = |(q.evt_status & q.evt_mask);
endmodule

/* File: src/usic_pkg.sv */
/*
 * Shared constants and carrier types of the interrupt controller:
 * register indices, bit positions, write masks, reset state and vector table.
 * Assumes the principal module and the bench both refer to it as usic_pkg::name.
 */
package usic_pkg;
	localparam int ADDR_W = 8;
	localparam int NSRC = 6;
	localparam int NEVT = 3;
	localparam int NEP = 4;
	localparam int PC_W = 12;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_INTC0 = 6'h0b;
	localparam logic [5:0] IDX_SEC_CTL = 6'h1e;
	localparam logic [5:0] IDX_EP_REQ = 6'h20;
	localparam logic [5:0] IDX_USB_CTL = 6'h21;
	localparam logic [5:0] IDX_SER1_CTL = 6'h22;
	localparam logic [5:0] IDX_SER2_CTL = 6'h23;
	localparam logic [5:0] IDX_EVT_STATUS = 6'h24;
	localparam logic [5:0] IDX_EVT_MASK = 6'h25;
	localparam logic [1:0] BYTE_OFS_ZERO = 2'h0;

	// primary control register bits
	localparam int B_GIE = 0;
	localparam int B_EEI = 1;
	localparam int B_ET0I = 2;
	localparam int B_ET1I = 3;
	localparam int B_EIF = 4;
	localparam int B_T0F = 5;
	localparam int B_T1F = 6;
	// secondary control register bits
	localparam int B_EUI = 0;
	localparam int B_ES1I = 1;
	localparam int B_ES2I = 2;
	localparam int B_USB_FLAG = 4;
	localparam int B_SER1_FLAG = 5;
	localparam int B_SER2_FLAG = 6;
	// usb control and serial control bits
	localparam int B_SUSPEND = 0;
	localparam int B_RESUME = 3;
	localparam int B_SER_EN = 4;
	// event status bits
	localparam int E_ACK = 0;
	localparam int E_STACK_BLOCK = 1;
	localparam int E_BUS_RESET = 2;

	localparam logic [7:0] INTC0_WMASK = 8'h7f;
	localparam logic [7:0] SEC_CTL_WMASK = 8'h77;
	localparam logic [7:0] USB_CTL_WMASK = 8'h09;

	// vectors by source index, index 0 highest priority
	localparam logic [NSRC-1:0][PC_W-1:0] VECTOR_TABLE = {
		12'h018, 12'h014, 12'h010, 12'h00c, 12'h008, 12'h004};

	typedef struct packed {
		logic phase2_pulse;
		logic stack_full;
		logic irq_return;
		logic plain_return;
		logic [PC_W-1:0] pc;
	} usic_core_t;

	typedef struct packed {
		logic ext_fall;
		logic timer0_ovf;
		logic timer1_ovf;
		logic serial1_done;
		logic serial2_done;
	} usic_src_evt_t;

	typedef struct packed {
		logic [NEP-1:0] ep_access;
		logic suspend;
		logic resume;
		logic bus_reset;
	} usic_usb_evt_t;

	typedef struct packed {
		logic valid;
		logic [PC_W-1:0] vector;
		logic [PC_W-1:0] push_pc;
	} usic_ack_t;

	typedef struct packed {
		logic [7:0] intc0;
		logic [7:0] sec_ctl;
		logic [NEP-1:0] ep_req;
		logic [7:0] usb_ctl;
		logic [7:0] ser1_ctl;
		logic [7:0] ser2_ctl;
		logic [NEVT-1:0] evt_status;
		logic [NEVT-1:0] evt_mask;
		logic in_service;
		logic [31:0] prdata;
		logic pslverr;
		usic_ack_t ack;
	} usic_state_t;

	localparam usic_state_t STATE_RESET = '0;
endpackage

/* File: verif/usic_core_model.sv */
/* sequencer partner: second-phase pulse every four cycles, pc jumping to the vector.
   assumes the bench pulses irq_return_req and plain_return_req for one cycle. */
`timescale 1ns/1ps
module usic_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire usic_pkg::usic_ack_t ack,
	input wire logic irq_return_req,
	input wire logic plain_return_req,
	input wire logic full,
	output usic_pkg::usic_core_t core
);
	logic [1:0] ph_q;
	// four-phase instruction cycle; pulse lands mid-cycle so events can fall between pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_q <= 2'h0;
			core <= '0;
		end else begin
			ph_q <= ph_q + 2'h1;
			core.phase2_pulse <= ph_q == 2'h1;
			core.stack_full <= full;
			core.irq_return <= irq_return_req;
			core.plain_return <= plain_return_req;
			core.pc <= ack.valid ? ack.vector : core.pc + 12'h001;
		end
	end
endmodule

/* File: verif/usic_ctrl_monitor.sv */
/* port checker for usic_ctrl.
   assumes it is bound to every usic_ctrl instance. */
`timescale 1ns/1ps
module usic_ctrl_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire usic_pkg::usic_core_t core,
	input wire usic_pkg::usic_ack_t ack,
	input wire logic global_irq_enable,
	input wire logic in_service
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ack tied to its pulse, stack, pc and enables
	property p_take; ack.valid |-> $past(core.phase2_pulse) && !$past(core.stack_full); endproperty
	a_take: assert property (p_take) else $error("ack off pulse or stack full");
	property p_pc; ack.valid |-> ack.push_pc == $past(core.pc); endproperty
	a_pc: assert property (p_pc) else $error("wrong pushed pc");
	property p_vec; ack.valid |-> ack.vector inside {12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018}; endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_off; ack.valid |-> !global_irq_enable && in_service; endproperty
	a_off: assert property (p_off) else $error("enable kept on ack");
	property p_mask; !global_irq_enable |=> !ack.valid; endproperty
	a_mask: assert property (p_mask) else $error("ack while disabled");
	property p_one; ack.valid |=> !ack.valid [*2]; endproperty
	a_one: assert property (p_one) else $error("nested ack");
	// enable already off means no acknowledge can race the return
	property p_irq_return; core.irq_return && !global_irq_enable && !(psel && penable && pwrite) |=> global_irq_enable;
	endproperty
	a_irq_return: assert property (p_irq_return) else $error("return left enable off");
	property p_plain_return; core.plain_return && !core.irq_return && !global_irq_enable && !(psel && penable && pwrite)
		|=> $stable(global_irq_enable); endproperty
	a_plain_return: assert property (p_plain_return) else $error("plain return changed enable");
	c_ack: cover property (ack.valid);
	c_full: cover property (core.phase2_pulse && core.stack_full);
	c_irq_return: cover property (core.irq_return ##1 global_irq_enable);
endmodule
bind usic_ctrl usic_ctrl_monitor usic_ctrl_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .core(core), .ack(ack), .global_irq_enable(global_irq_enable),
	.in_service(in_service));

/* File: verif/tb.sv */
/* bench for usic_ctrl with the sequencer model.
   assumes usic_pkg, the design and the model compiled first. */
`timescale 1ns/1ps
module tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic irq_return_req = 1'b0, plain_return_req = 1'b0, full = 1'b0, pready, pslverr, gie, in_service, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	usic_pkg::usic_core_t core;
	usic_pkg::usic_src_evt_t src_evt = '0;
	usic_pkg::usic_usb_evt_t usb_evt = '0;
	usic_pkg::usic_ack_t ack;
	int fails = 0, num_checks = 0;
	usic_ctrl usic_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core(core), .src_evt(src_evt), .usb_evt(usb_evt), .ack(ack), .global_irq_enable(gie),
		.in_service(in_service), .irq(irq));
	usic_core_model usic_core_model_inst (.pclk(pclk), .presetn(presetn), .ack(ack), .irq_return_req(irq_return_req),
		.plain_return_req(plain_return_req), .full(full), .core(core));
	// 4 ns clock
	initial begin
		forever #2 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// apb transfer; idle edge first so back-to-back calls never double-drive
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 50) begin
			fails++;
			summarize;
		end
	endtask
	task automatic wait_ack(input logic [11:0] v);
		int n;
		for (n = 0; n < 60 && ack.valid !== 1'b1; n++)
			@(negedge pclk);
		if (n == 60) begin
			fails++;
			summarize;
		end
		chk("vector", 32'(ack.vector), 32'(v));
		chk("gie", 32'(gie), 32'h0);
		chk("in_service", 32'(in_service), 32'h1);
	endtask
	task automatic return_pulse(input logic intr);
		@(posedge pclk);
		irq_return_req <= intr;
		plain_return_req <= !intr;
		@(posedge pclk);
		irq_return_req <= 1'b0;
		plain_return_req <= 1'b0;
		repeat (2) @(negedge pclk);
		chk("gie_return", 32'(gie), 32'(intr));
		chk("in_service_return", 32'(in_service), 32'h0);
	endtask
	// usb events while globally off, then service, irq and clear
	task automatic t_usb;
		apb(1, 8'h94, 32'h1);
		apb(1, 8'h78, 32'h1);
		@(posedge pclk);
		usb_evt <= '{ep_access: 4'h5, suspend: 1'b1, resume: 1'b1, bus_reset: 1'b0};
		@(posedge pclk);
		usb_evt <= '0;
		apb(0, 8'h80, 32'h0);
		chk("ep_req", rd, 32'h5);
		apb(0, 8'h84, 32'h0);
		chk("usb_ctl", rd, 32'h9);
		apb(0, 8'h78, 32'h0);
		chk("sec", rd, 32'h11);
		apb(1, 8'h2c, 32'h1);
		wait_ack(12'h010);
		apb(0, 8'h78, 32'h0);
		chk("sec_ack", rd, 32'h1);
		chk("irq_on", 32'(irq), 32'h1);
		apb(1, 8'h90, 32'h1);
		@(negedge pclk);
		chk("irq_off", 32'(irq), 32'h0);
		apb(1, 8'h80, 32'h0);
		return_pulse(1'b1);
	endtask
	// all six sources at once, stack full first, then served one by one
	task automatic t_prio;
		apb(0, 8'h04, 32'h0);
		chk("slverr", 32'(pslverr), 32'h1);
		apb(1, 8'h2c, 32'h0e);
		apb(1, 8'h94, 32'h0);
		apb(1, 8'h78, 32'h7);
		apb(1, 8'h88, 32'h10);
		apb(1, 8'h8c, 32'h10);
		@(posedge pclk);
		src_evt <= '1;
		usb_evt.bus_reset <= 1'b1;
		@(posedge pclk);
		src_evt <= '0;
		usb_evt <= '0;
		full <= 1'b1;
		apb(0, 8'h78, 32'h0);
		chk("sec_all", rd, 32'h77);
		apb(1, 8'h2c, 32'h7f);
		repeat (12) @(negedge pclk);
		chk("in_svc_full", 32'(in_service), 32'h0);
		@(posedge pclk);
		full <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			wait_ack(usic_pkg::VECTOR_TABLE[i]);
			chk("irq_masked", 32'(irq), 32'h0);
			return_pulse(1'b0);
			apb(0, 8'h2c, 32'h0);
			apb(1, 8'h2c, rd | 32'h1);
		end
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h78, 32'h0);
		chk("sec_reset", rd, 32'h0);
		t_usb;
		t_prio;
		summarize;
	end
endmodule
